// [design/mgc_top.sv]
// Multifunction pin controller with comparator and protection status
`timescale 1ns/1ps
`include "mgc_map.svh"

module mgc_top #(
    parameter int FILTER_NS     = `MGC_FILTER_NS,
    parameter int CLK_PERIOD_NS = `MGC_CLK_PERIOD_NS
) (
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    // Register port
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    input  wire logic [7:0]            reg_addr_i,
    input  wire logic [15:0]           reg_wdata_i,
    output logic [15:0]                reg_rdata_o,
    output logic                       reg_rvalid_o,
    // Pin
    input  wire logic                  pin_i,
    output logic                       pin_o,
    output logic                       pin_oe_o,
    // Status sources
    input  wire logic                  protect_active_i,
    input  wire logic [3:0]            comparator_raw_i,
    input  wire logic [3:0]            window_compare_raw_i,
    input  wire logic                  window_latch_enable_i,
    input  wire logic [3:0]            comparator_flag_clear_i,
    input  wire logic                  storage_busy_flag_i,
    input  wire logic [3:0]            channel_busy_i,
    // Triggers to the rest of the device
    output logic                       fault_snapshot_o,
    output logic                       protect_start_o,
    output logic                       output_clear_o,
    output logic [3:0]                 current_output_down_o,
    output logic [3:0]                 voltage_output_down_o,
    output mgc_pkg::mgc_chan_pulse_t   chan_pulse_o,
    output logic                       device_reset_o,
    output logic                       storage_program_allow_o,
    output logic                       reg_write_lock_o,
    output logic [3:0]                 comparator_latch_reset_o
);

    // Filter hold time rounded up to whole cycles, at least one
    localparam int FILTER_CYCLES_RAW = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILTER_CYCLES     = (FILTER_CYCLES_RAW < 1) ? 1 : FILTER_CYCLES_RAW;

    // Pick the status bit that drives the pin
    function automatic logic out_source(input logic [3:0] sel,
                                        input logic       storage_busy,
                                        input logic [3:0] ch_busy,
                                        input logic [3:0] win);
        logic r;
        r = 1'b0;
        if (sel == `MGC_OSEL_STORAGE) begin
            r = storage_busy;
        end else if (sel[3:2] == `MGC_OSEL_GRP_BUSY) begin
            r = ch_busy[sel[1:0]];
        end else if (sel[3:2] == `MGC_OSEL_GRP_WIN) begin
            r = win[sel[1:0]];
        end
        return r;
    endfunction : out_source

    mgc_pkg::mgc_cfg_t    cfg;
    mgc_pkg::mgc_cfg_t    next_cfg;
    mgc_pkg::mgc_status_t status;
    logic [7:0]           cmp_s1;
    logic [7:0]           cmp_s2;
    logic [7:0]           cmp_s3;
    logic [7:0]           cmp_agreed;
    logic [7:0]           next_cmp_agreed;
    logic [3:0]           win_latched;
    logic [3:0]           next_win_latched;
    logic [3:0]           win_view;
    logic                 protect_flag;
    logic                 next_protect_flag;
    logic [15:0]          next_rdata;
    logic                 status_read;
    logic                 pin_level;
    logic                 pin_rise;
    logic                 pin_fall;
    logic                 fn_on;
    logic [3:0]           mask;

    logic                 next_fault_snapshot;
    logic                 next_protect_start;
    logic                 next_output_clear;
    logic [3:0]           next_cur_down;
    logic [3:0]           next_volt_down;
    mgc_pkg::mgc_chan_pulse_t next_chan_pulse;
    logic                 next_device_reset;
    logic                 next_storage_allow;
    logic                 next_reg_lock;
    logic                 next_pin_o;
    logic                 next_pin_oe;

    // Pin conditioning; glitch filter switched on by the deglitch bit
    mgc_pin_filter #(
        .FILTER_CYCLES (FILTER_CYCLES)
    ) u_pin_filter (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .pin_i       (pin_i),
        .filter_en_i (cfg.deglitch_en),
        .level_o     (pin_level),
        .rise_o      (pin_rise),
        .fall_o      (pin_fall)
    );

    // Configuration write; a locked map ignores writes to it
    always_comb begin
        next_cfg = cfg;
        if (reg_wr_i && (reg_addr_i == `MGC_ADDR_CFG) && !reg_write_lock_o) begin
            next_cfg          = mgc_pkg::mgc_cfg_t'(reg_wdata_i);
            next_cfg.unused14 = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cfg <= mgc_pkg::mgc_cfg_t'(`MGC_CFG_RESET);
        end else begin
            cfg <= next_cfg;
        end
    end

    // Comparator and window inputs come from the analog side, so synchronise
    always_comb begin
        next_cmp_agreed = cmp_agreed;
        for (int i = 0; i < 8; i++) begin
            if (cmp_s2[i] == cmp_s3[i]) begin
                next_cmp_agreed[i] = cmp_s3[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cmp_s1     <= 8'h00;
            cmp_s2     <= 8'h00;
            cmp_s3     <= 8'h00;
            cmp_agreed <= 8'h00;
        end else begin
            cmp_s1     <= {window_compare_raw_i, comparator_raw_i};
            cmp_s2     <= cmp_s1;
            cmp_s3     <= cmp_s2;
            cmp_agreed <= next_cmp_agreed;
        end
    end

    // Window latch: a new result wins over a clear in the same cycle
    assign win_view = window_latch_enable_i ? win_latched : cmp_agreed[7:4];

    always_comb begin
        next_win_latched = (win_latched & ~comparator_flag_clear_i) | cmp_agreed[7:4];
    end

    // Protect flag: clear on status read, but an active protect keeps it set
    assign status_read = reg_rd_i && (reg_addr_i == `MGC_ADDR_STATUS);

    always_comb begin
        next_protect_flag = protect_flag;
        if (status_read) begin
            next_protect_flag = 1'b0;
        end
        if (protect_active_i) begin
            next_protect_flag = 1'b1;
        end
    end

    always_comb begin
        status                       = '0;
        status.protect_flag          = protect_flag;
        status.window_compare_result = win_view;
        status.comparator_sync_flag  = cmp_agreed[3:0];
    end

    // Read data, one cycle after the request; unmapped reads give zero
    always_comb begin
        next_rdata = `MGC_RDATA_RESET;
        if (reg_rd_i && (reg_addr_i == `MGC_ADDR_CFG)) begin
            next_rdata = cfg;
        end else if (status_read) begin
            next_rdata = status;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            win_latched              <= 4'h0;
            protect_flag             <= 1'b0;
            reg_rdata_o              <= `MGC_RDATA_RESET;
            reg_rvalid_o             <= 1'b0;
            comparator_latch_reset_o <= 4'h0;
        end else begin
            win_latched              <= next_win_latched;
            protect_flag             <= next_protect_flag;
            reg_rdata_o              <= next_rdata;
            reg_rvalid_o             <= reg_rd_i;
            comparator_latch_reset_o <= comparator_flag_clear_i;
        end
    end

    // Input functions act only with input mode on
    assign fn_on = cfg.in_en;
    assign mask  = cfg.ch_mask;

    // Trigger next values; pulses last one cycle, power and lock states hold
    always_comb begin
        next_fault_snapshot = 1'b0;
        next_protect_start  = 1'b0;
        next_output_clear   = 1'b0;
        next_cur_down       = current_output_down_o;
        next_volt_down      = voltage_output_down_o;
        next_chan_pulse     = '0;
        next_device_reset   = device_reset_o;
        next_storage_allow  = storage_program_allow_o;
        next_reg_lock       = reg_write_lock_o;
        if (fn_on) begin
            case (cfg.in_func)
                mgc_pkg::MGC_IN_FAULT_SNAP: begin
                    next_fault_snapshot = pin_fall;
                end
                mgc_pkg::MGC_IN_CUR_PWR: begin
                    if (pin_fall) begin
                        next_cur_down = current_output_down_o | mask;
                    end else if (pin_rise) begin
                        next_cur_down = current_output_down_o & ~mask;
                    end
                end
                mgc_pkg::MGC_IN_VOLT_PWR: begin
                    if (pin_fall) begin
                        next_volt_down = voltage_output_down_o | mask;
                    end else if (pin_rise) begin
                        next_volt_down = voltage_output_down_o & ~mask;
                    end
                end
                mgc_pkg::MGC_IN_PROTECT: begin
                    next_protect_start = pin_fall;
                end
                mgc_pkg::MGC_IN_CLEAR: begin
                    next_output_clear = ~pin_level;
                end
                mgc_pkg::MGC_IN_LOAD: begin
                    next_chan_pulse.load_strobe = pin_fall ? mask : 4'h0;
                end
                mgc_pkg::MGC_IN_FUNC_GEN: begin
                    next_chan_pulse.func_stop  = pin_fall ? mask : 4'h0;
                    next_chan_pulse.func_start = pin_rise ? mask : 4'h0;
                end
                mgc_pkg::MGC_IN_MARGIN: begin
                    next_chan_pulse.margin_low  = pin_fall ? mask : 4'h0;
                    next_chan_pulse.margin_high = pin_rise ? mask : 4'h0;
                end
                mgc_pkg::MGC_IN_RESET: begin
                    if (pin_fall) begin
                        next_device_reset = 1'b1;
                    end else if (pin_rise) begin
                        next_device_reset = 1'b0;
                    end
                end
                mgc_pkg::MGC_IN_NVM_PROT: begin
                    if (pin_fall) begin
                        next_storage_allow = 1'b1;
                    end else if (pin_rise) begin
                        next_storage_allow = 1'b0;
                    end
                end
                mgc_pkg::MGC_IN_MAP_LOCK: begin
                    if (pin_fall) begin
                        next_reg_lock = 1'b0;
                    end else if (pin_rise) begin
                        next_reg_lock = 1'b1;
                    end
                end
                default: begin
                    // Invalid codes raise no pulse; held power, reset and lock states keep their values
                    next_fault_snapshot = 1'b0;
                end
            endcase
        end
    end

    // Pin output: mux registered so the pad sees a clean level
    always_comb begin
        next_pin_oe = cfg.out_en;
        next_pin_o  = 1'b0;
        if (cfg.out_en) begin
            next_pin_o = out_source(cfg.out_sel, storage_busy_flag_i,
                                    channel_busy_i, win_view);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            fault_snapshot_o        <= 1'b0;
            protect_start_o         <= 1'b0;
            output_clear_o          <= 1'b0;
            current_output_down_o   <= 4'h0;
            voltage_output_down_o   <= 4'h0;
            chan_pulse_o            <= '0;
            device_reset_o          <= 1'b0;
            storage_program_allow_o <= 1'b0;
            reg_write_lock_o        <= 1'b0;
            pin_o                   <= 1'b0;
            pin_oe_o                <= 1'b0;
        end else begin
            fault_snapshot_o        <= next_fault_snapshot;
            protect_start_o         <= next_protect_start;
            output_clear_o          <= next_output_clear;
            current_output_down_o   <= next_cur_down;
            voltage_output_down_o   <= next_volt_down;
            chan_pulse_o            <= next_chan_pulse;
            device_reset_o          <= next_device_reset;
            storage_program_allow_o <= next_storage_allow;
            reg_write_lock_o        <= next_reg_lock;
            pin_o                   <= next_pin_o;
            pin_oe_o                <= next_pin_oe;
        end
    end

endmodule : mgc_top

// [design/mgc_map.svh]
// Register offsets, codes and timing constants of the pin function controller
`ifndef MGC_MAP_SVH
`define MGC_MAP_SVH

// Register offsets on the internal register port
`define MGC_ADDR_STATUS      8'h23
`define MGC_ADDR_CFG         8'h24

// Reset values
`define MGC_CFG_RESET        16'h0000
`define MGC_RDATA_RESET      16'h0000

// Output source selection codes
`define MGC_OSEL_STORAGE     4'h1
`define MGC_OSEL_GRP_BUSY    2'h1
`define MGC_OSEL_GRP_WIN     2'h2

// Glitch filter hold time and clock period, both in ns
`define MGC_FILTER_NS        1000
`define MGC_CLK_PERIOD_NS    10

// Idle level of the pin after reset
`define MGC_PIN_IDLE         1'b1

`endif

// [design/mgc_pkg.sv]
// Types shared by the pin function controller files
package mgc_pkg;

    // Pin configuration word, laid out as the register
    typedef struct packed {
        logic       deglitch_en;   // input_deglitch_enable
        logic       unused14;
        logic       out_en;        // pin_output_enable
        logic [3:0] out_sel;       // pin_output_source_select
        logic [3:0] ch_mask;       // input_channel_mask
        logic [3:0] in_func;       // pin_input_function
        logic       in_en;         // pin_input_enable
    } mgc_cfg_t;

    // Comparator and protection status word
    typedef struct packed {
        logic [6:0] unused;
        logic       protect_flag;
        logic [3:0] window_compare_result;
        logic [3:0] comparator_sync_flag;
    } mgc_status_t;

    // Input function codes
    typedef enum logic [3:0] {
        MGC_IN_FAULT_SNAP = 4'b0010,
        MGC_IN_CUR_PWR    = 4'b0011,
        MGC_IN_VOLT_PWR   = 4'b0100,
        MGC_IN_PROTECT    = 4'b0101,
        MGC_IN_CLEAR      = 4'b0111,
        MGC_IN_LOAD       = 4'b1000,
        MGC_IN_FUNC_GEN   = 4'b1001,
        MGC_IN_MARGIN     = 4'b1010,
        MGC_IN_RESET      = 4'b1011,
        MGC_IN_NVM_PROT   = 4'b1100,
        MGC_IN_MAP_LOCK   = 4'b1101
    } mgc_in_func_t;

    // Per-channel pulse group driven to the datapath
    typedef struct packed {
        logic [3:0] load_strobe;
        logic [3:0] func_stop;
        logic [3:0] func_start;
        logic [3:0] margin_low;
        logic [3:0] margin_high;
    } mgc_chan_pulse_t;

endpackage : mgc_pkg

// [design/mgc_pin_filter.sv]
// Pin input synchroniser, optional glitch filter and edge detector
`timescale 1ns/1ps
`include "mgc_map.svh"

module mgc_pin_filter #(
    parameter int FILTER_CYCLES = 100
) (
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic pin_i,
    input  wire logic filter_en_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);

    localparam int CW = $clog2(FILTER_CYCLES + 1);

    logic          sync1;
    logic          sync2;
    logic          sync3;
    logic [CW-1:0] cnt;
    logic          next_level;
    logic          next_rise;
    logic          next_fall;
    logic [CW-1:0] next_cnt;

    // Next level: change counts when stages two and three agree
    always_comb begin
        next_level = level_o;
        next_cnt   = '0;
        if ((sync2 == sync3) && (sync3 != level_o)) begin
            if (!filter_en_i) begin
                next_level = sync3;
            end else if (cnt >= CW'(FILTER_CYCLES - 1)) begin
                next_level = sync3;
            end else begin
                next_cnt   = cnt + CW'(1);
            end
        end
        next_rise = next_level & ~level_o;
        next_fall = ~next_level & level_o;
    end

    // Sync chain and filter state; first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sync1   <= `MGC_PIN_IDLE;
            sync2   <= `MGC_PIN_IDLE;
            sync3   <= `MGC_PIN_IDLE;
            level_o <= `MGC_PIN_IDLE;
            rise_o  <= 1'b0;
            fall_o  <= 1'b0;
            cnt     <= '0;
        end else begin
            sync1   <= pin_i;
            sync2   <= sync1;
            sync3   <= sync2;
            level_o <= next_level;
            rise_o  <= next_rise;
            fall_o  <= next_fall;
            cnt     <= next_cnt;
        end
    end

endmodule : mgc_pin_filter

// [dv/mgc_pin_ext.sv]
// External driver model standing on the multifunction pin
`timescale 1ns/1ps

module mgc_pin_ext (
    input  wire logic lvl_i,
    input  wire logic pin_o,
    input  wire logic pin_oe_o,
    output logic      pin_w_o
);
    // Device drive wins; the driver backs off so the two never fight
    always_comb begin
        pin_w_o = pin_oe_o ? pin_o : lvl_i;
    end
endmodule : mgc_pin_ext

// [dv/mgc_chk.sv]
// Port-level assertions for the pin function controller
`timescale 1ns/1ps

module mgc_chk #(
    parameter int FILTER_NS     = 1000,
    parameter int CLK_PERIOD_NS = 10
) (
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        reg_rvalid_o,
    input wire logic        pin_i,
    input wire logic        pin_o,
    input wire logic        pin_oe_o,
    input wire logic        protect_active_i,
    input wire logic        storage_busy_flag_i,
    input wire logic [3:0]  comparator_flag_clear_i,
    input wire logic [3:0]  comparator_latch_reset_o,
    input wire logic        fault_snapshot_o,
    input wire logic        output_clear_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    // Register reads seen on the port
    sequence cfg_rd;
        reg_rd_i && reg_addr_i == 8'h24;
    endsequence
    sequence quiet_rd;
        reg_rd_i && reg_addr_i == 8'h23 && !protect_active_i;
    endsequence

    rd_valid_a: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read without valid");
    prot_set_a: assert property (protect_active_i ##1 quiet_rd |=> reg_rdata_o[8])
        else $error("protect flag not set");
    prot_clear_a: assert property (quiet_rd [*2] |=> !reg_rdata_o[8])
        else $error("protect flag not cleared by read");
    oe_mirror_a: assert property (cfg_rd |=> pin_oe_o == reg_rdata_o[13])
        else $error("pin enable differs from config");
    osel_busy_a: assert property (cfg_rd ##1 reg_rdata_o[13:9] == 5'h11 |-> pin_o == $past(storage_busy_flag_i))
        else $error("pin not following storage busy");
    flag_clr_a: assert property (|comparator_flag_clear_i |=> comparator_latch_reset_o == $past(comparator_flag_clear_i))
        else $error("latch reset not following clear");
    snap_pulse_a: assert property (fault_snapshot_o |=> !fault_snapshot_o)
        else $error("snapshot pulse too long");
    // Pin sync chain delays the level by four edges, so look back that far
    clear_low_a: assert property ($rose(output_clear_o) |-> !$past(pin_i, 4))
        else $error("clear raised with pin high");
endmodule : mgc_chk

bind mgc_top mgc_chk #(
    .FILTER_NS     (FILTER_NS),
    .CLK_PERIOD_NS (CLK_PERIOD_NS)
) mgc_chk_inst (
    .clk_i                    (clk_i),
    .srst_i                   (srst_i),
    .reg_rd_i                 (reg_rd_i),
    .reg_addr_i               (reg_addr_i),
    .reg_rdata_o              (reg_rdata_o),
    .reg_rvalid_o             (reg_rvalid_o),
    .pin_i                    (pin_i),
    .pin_o                    (pin_o),
    .pin_oe_o                 (pin_oe_o),
    .protect_active_i         (protect_active_i),
    .storage_busy_flag_i      (storage_busy_flag_i),
    .comparator_flag_clear_i  (comparator_flag_clear_i),
    .comparator_latch_reset_o (comparator_latch_reset_o),
    .fault_snapshot_o         (fault_snapshot_o),
    .output_clear_o           (output_clear_o)
);

// [dv/tb_top.sv]
// Self-checking bench for the pin function controller
`timescale 1ns/1ps

module tb_top;
    logic clk_i = 1'b0, srst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, lvl = 1'b1, hclr = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0000, seed = 16'h95a6, r, cfg, reg_rdata_o;
    logic protect_active_i = 1'b0, window_latch_enable_i = 1'b0, storage_busy_flag_i = 1'b0;
    logic [3:0] comparator_raw_i = 4'h0, window_compare_raw_i = 4'h0, comparator_flag_clear_i = 4'h0;
    logic [3:0] channel_busy_i = 4'h0, current_output_down_o, voltage_output_down_o, comparator_latch_reset_o;
    logic reg_rvalid_o, pin_i, pin_o, pin_oe_o, fault_snapshot_o, protect_start_o, output_clear_o;
    logic device_reset_o, storage_program_allow_o, reg_write_lock_o;
    mgc_pkg::mgc_chan_pulse_t chan_pulse_o;
    logic [21:0] hits = 22'h0;
    logic [15:0] exp_q[$];
    logic [3:0] codes[12] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd};
    int n_mismatch = 0, comparisons = 0;
    wire [33:0] obs = {output_clear_o, current_output_down_o, voltage_output_down_o, device_reset_o,
                       storage_program_allow_o, reg_write_lock_o, hits};

    // Short filter keeps the glitch test quick: 5 cycles
    mgc_top #(.FILTER_NS(50)) mgc_top_inst (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o),
        .pin_i(pin_i),
        .pin_o(pin_o),
        .pin_oe_o(pin_oe_o),
        .protect_active_i(protect_active_i),
        .comparator_raw_i(comparator_raw_i),
        .window_compare_raw_i(window_compare_raw_i),
        .window_latch_enable_i(window_latch_enable_i),
        .comparator_flag_clear_i(comparator_flag_clear_i),
        .storage_busy_flag_i(storage_busy_flag_i),
        .channel_busy_i(channel_busy_i),
        .fault_snapshot_o(fault_snapshot_o),
        .protect_start_o(protect_start_o),
        .output_clear_o(output_clear_o),
        .current_output_down_o(current_output_down_o),
        .voltage_output_down_o(voltage_output_down_o),
        .chan_pulse_o(chan_pulse_o),
        .device_reset_o(device_reset_o),
        .storage_program_allow_o(storage_program_allow_o),
        .reg_write_lock_o(reg_write_lock_o),
        .comparator_latch_reset_o(comparator_latch_reset_o)
    );
    mgc_pin_ext mgc_pin_ext_inst (.lvl_i(lvl), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pin_w_o(pin_i));

    always #5 clk_i = ~clk_i;
    // Sticky record of trigger pulses, so one-cycle pulses are never missed
    always @(posedge clk_i) hits <= hclr ? 22'h0 : hits | {fault_snapshot_o, protect_start_o, chan_pulse_o};
    // Oldest noted read result against each answer
    always @(negedge clk_i) if (reg_rvalid_o === 1'b1) check("rdata", 34'(reg_rdata_o), 34'(exp_q.pop_front()));

    function automatic logic [15:0] xs();
        seed = seed ^ (seed << 7);
        seed = seed ^ (seed >> 9);
        seed = seed ^ (seed << 8);
        return seed;
    endfunction : xs

    // Expected levels and pulses after one pin edge
    function automatic logic [33:0] ex(input logic [3:0] c, input logic [3:0] m, input logic f);
        ex = 34'h0;
        case (c)
            4'h2: ex[21] = f;
            4'h3: ex[32:29] = f ? m : 4'h0;
            4'h4: ex[28:25] = f ? m : 4'h0;
            4'h5: ex[20] = f;
            4'h7: ex[33] = f;
            4'h8: ex[19:16] = f ? m : 4'h0;
            4'h9: ex[15:8] = f ? {m, 4'h0} : {4'h0, m};
            4'ha: ex[7:0] = f ? {m, 4'h0} : {4'h0, m};
            4'hb: ex[24] = f;
            4'hc: ex[23] = f;
            4'hd: ex[22] = !f;
            default: ex = 34'h0;
        endcase
    endfunction : ex

    task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        exp_q.push_back(e);
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
    endtask : rd

    task automatic pin(input logic v, input int n);
        @(posedge clk_i);
        lvl <= v;
        hclr <= 1'b1;
        @(posedge clk_i);
        hclr <= 1'b0;
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask : pin

    // One pulse on the pin under a given function, filter and enable
    task automatic run(input logic [3:0] c, input logic en, input logic f);
        r = xs();
        cfg = {f, 2'b00, 4'h0, r[3:0], c, en};
        wr(8'h24, cfg);
        if (f) begin
            pin(1'b0, 0);
            pin(1'b1, 16);
            check("glitch", obs, 34'h0);
        end
        pin(1'b0, 16);
        check("fall", obs, en ? ex(c, r[3:0], 1'b1) : 34'h0);
        pin(1'b1, 16);
        check("rise", obs, en ? ex(c, r[3:0], 1'b0) : 34'h0);
    endtask : run

    task automatic test_done();
        if (n_mismatch == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    initial begin
        #500000;
        n_mismatch++;
        test_done();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        rd(8'h24, 16'h0000);
        rd(8'h23, 16'h0000);
        rd(8'h30, 16'h0000);
        r = xs();
        wr(8'h24, r & 16'hfffe);
        rd(8'h24, r & 16'hbffe);
        // Protect flag: set by the sequence, cleared by back-to-back reads
        @(posedge clk_i);
        protect_active_i <= 1'b1;
        @(posedge clk_i);
        protect_active_i <= 1'b0;
        reg_rd_i <= 1'b1;
        reg_addr_i <= 8'h23;
        exp_q.push_back(16'h0100);
        exp_q.push_back(16'h0000);
        exp_q.push_back(16'h0000);
        repeat (3) @(posedge clk_i);
        reg_rd_i <= 1'b0;
        r = xs();
        comparator_raw_i <= r[3:0];
        window_compare_raw_i <= r[7:4];
        comparator_flag_clear_i <= r[11:8];
        @(posedge clk_i);
        comparator_flag_clear_i <= 4'h0;
        repeat (8) @(posedge clk_i);
        rd(8'h23, {8'h00, r[7:0]});
        // Latched window results outlive their inputs until a clear
        @(posedge clk_i);
        window_latch_enable_i <= 1'b1;
        window_compare_raw_i <= 4'h0;
        repeat (6) @(posedge clk_i);
        rd(8'h23, {8'h00, r[7:0]});
        comparator_flag_clear_i <= 4'hf;
        @(posedge clk_i);
        comparator_flag_clear_i <= 4'h0;
        @(negedge clk_i);
        check("latch_reset", 34'(comparator_latch_reset_o), 34'h0f);
        rd(8'h23, {12'h000, r[3:0]});
        window_latch_enable_i <= 1'b0;
        // Every output source code, unassigned ones drive low
        for (int s = 0; s < 16; s++) begin
            @(posedge clk_i);
            r = xs();
            storage_busy_flag_i <= r[4];
            channel_busy_i <= r[3:0];
            window_compare_raw_i <= r[7:4];
            wr(8'h24, {3'b001, 4'(s), 9'h000});
            repeat (6) @(posedge clk_i);
            rd(8'h24, {3'b001, 4'(s), 9'h000});
            @(negedge clk_i);
            check("pin", 34'({pin_oe_o, pin_o}), 34'({1'b1, s == 1 ? r[4] : (s >= 4 && s < 12) ? r[s - 4] : 1'b0}));
        end
        run(4'h3, 1'b0, 1'b0);
        run(4'h2, 1'b1, 1'b1);
        for (int i = 0; i < 12; i++) run(codes[i], 1'b1, 1'b0);
        // Locked map refuses the write until a falling edge unlocks it
        wr(8'h24, 16'h0000);
        rd(8'h24, cfg);
        pin(1'b0, 16);
        wr(8'h24, 16'h0000);
        rd(8'h24, 16'h0000);
        pin(1'b1, 16);
        check("unlocked", obs, 34'h0);
        repeat (4) @(posedge clk_i);
        test_done();
    end
endmodule : tb_top
